// ---- include/dma_ctrl_pkg.sv ----
/*
  dma_ctrl_pkg: constants and types shared by the two-channel dma block.
  holds register indices, control word field positions, step sizes, the
  handshake mode encoding and the transfer engine state type.
  assumes a 32-bit ahb-lite register bus with one register per aligned word.
*/
package dma_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map: index = byte address / 4
  // ----------------------------------------------------------------
  localparam logic [3:0] CH0_BLOCK = 4'hC;
  localparam logic [3:0] CH1_BLOCK = 4'hD;
  localparam logic [3:0] REG_SRC_LO = 4'h0;
  localparam logic [3:0] REG_SRC_HI = 4'h2;
  localparam logic [3:0] REG_DST_LO = 4'h4;
  localparam logic [3:0] REG_DST_HI = 4'h6;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hA;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // ----------------------------------------------------------------
  // channel_control_word fields
  // ----------------------------------------------------------------
  localparam int DST_SPACE_BIT = 15;
  localparam int DST_DOWN_BIT = 14;
  localparam int DST_UP_BIT = 13;
  localparam int SRC_SPACE_BIT = 12;
  localparam int SRC_DOWN_BIT = 11;
  localparam int SRC_UP_BIT = 10;
  localparam int COUNT_END_HALT_BIT = 9;
  localparam int IRQ_ENABLE_BIT = 8;
  localparam int HANDSHAKE_MSB = 7;
  localparam int HANDSHAKE_LSB = 6;
  localparam int RANK_BIT = 5;
  localparam int TIMER_REQUEST_ENABLE_BIT = 4;
  localparam int RUN_WRITE_GATE_BIT = 2;
  localparam int CHANNEL_RUN_BIT = 1;
  localparam int WORD_BIT = 0;
  // bits 3 and 2 are never stored, bit 1 lives in its own flop
  localparam logic [15:0] CTRL_STORE_MASK = 16'hFFF1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // pointers, counts and bus answers
  // ----------------------------------------------------------------
  localparam logic [19:0] BYTE_STEP = 20'h00001;
  localparam logic [19:0] WORD_STEP = 20'h00002;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    SYNC_NONE = 2'h0,
    SYNC_SOURCE = 2'h1,
    SYNC_DEST = 2'h2,
    SYNC_UNUSED = 2'h3
  } handshake_e;

  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_FETCH,
    XFER_STORE
  } xfer_state_e;

endpackage

// ---- rtl/dma_channel_regs.sv ----
/*
  dma_channel_regs: one channel's pointers, transfer count, control word
  and run bit, with stepping on each completed transfer and termination on the last.
  assumes paced request and timer tick are already in the clock domain.
*/
`timescale 1ns/1ps
module dma_channel_regs
  import dma_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // register writes
  input wire logic wr_en_in,
  input wire logic [3:0] wr_reg_in,
  input wire logic [15:0] wdata_in,
  // request sources and completion
  input wire logic drq_in,
  input wire logic timer_tick_in,
  input wire logic done_in,
  // state seen by the engine and readback
  output logic req_out,
  output logic [15:0] ctrl_out,
  output logic [19:0] src_addr_out,
  output logic [19:0] dst_addr_out,
  output logic [15:0] count_out,
  output logic irq_out
);

  logic [15:0] ctrl_q, ctrl_d;
  logic run_q, run_d;
  logic [19:0] src_q, src_d, dst_q, dst_d;
  logic [15:0] count_q, count_d;
  logic timer_pend_q, timer_pend_d;
  logic irq_q;
  logic [19:0] step;
  handshake_e mode;
  logic unsync, paced, last_xfer, end_halts, count_held;

  // step a pointer: both or neither direction bit holds it
  function automatic logic [19:0] step_ptr(input logic [19:0] p, input logic up,
                                           input logic down, input logic [19:0] s);
    logic [19:0] r;
    r = p;
    if (up && !down)
      r = p + s;
    else if (down && !up)
      r = p - s;
    return r;
  endfunction

  // mode decode straight from the live control word
  assign step = ctrl_q[WORD_BIT] ? WORD_STEP : BYTE_STEP;
  assign mode = handshake_e'(ctrl_q[HANDSHAKE_MSB:HANDSHAKE_LSB]);
  assign unsync = mode == SYNC_NONE;
  assign paced = (mode == SYNC_SOURCE) || (mode == SYNC_DEST);
  assign last_xfer = done_in && (count_q == COUNT_ONE);
  assign end_halts = ctrl_q[COUNT_END_HALT_BIT] || unsync;
  assign count_held = ctrl_q[COUNT_END_HALT_BIT] && (count_q == COUNT_ZERO);
  assign req_out = run_q && (unsync || (paced && (drq_in || timer_pend_q)
                   && !count_held));

  // next state: hardware updates first, software writes override
  always_comb
  begin
    ctrl_d = ctrl_q;
    run_d = run_q;
    src_d = src_q;
    dst_d = dst_q;
    count_d = count_q;
    timer_pend_d = (timer_pend_q && !done_in) ||
                   (timer_tick_in && ctrl_q[TIMER_REQUEST_ENABLE_BIT]);
    if (done_in)
    begin
      src_d = step_ptr(src_q, ctrl_q[SRC_UP_BIT], ctrl_q[SRC_DOWN_BIT], step);
      dst_d = step_ptr(dst_q, ctrl_q[DST_UP_BIT], ctrl_q[DST_DOWN_BIT], step);
      count_d = count_q - COUNT_ONE;
    end
    if (last_xfer && unsync)
      run_d = 1'b0;
    if (wr_en_in)
    begin
      unique case (wr_reg_in)
        REG_SRC_LO: src_d[15:0] = wdata_in;
        REG_SRC_HI: src_d[19:16] = wdata_in[3:0];
        REG_DST_LO: dst_d[15:0] = wdata_in;
        REG_DST_HI: dst_d[19:16] = wdata_in[3:0];
        REG_COUNT: count_d = wdata_in;
        REG_CTRL:
        begin
          ctrl_d = wdata_in & CTRL_STORE_MASK;
          if (wdata_in[RUN_WRITE_GATE_BIT])
            run_d = wdata_in[CHANNEL_RUN_BIT];
        end
        default: ;
      endcase
    end
  end

  // state flops; reset leaves the channel stopped
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_q <= CTRL_RESET;
      run_q <= 1'b0;
      src_q <= '0;
      dst_q <= '0;
      count_q <= COUNT_ZERO;
      timer_pend_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      run_q <= run_d;
      src_q <= src_d;
      dst_q <= dst_d;
      count_q <= count_d;
      timer_pend_q <= timer_pend_d;
      irq_q <= last_xfer && end_halts && ctrl_q[IRQ_ENABLE_BIT];
    end
  end

  // readback: run bit merged in, gate and spare bits read zero
  always_comb
  begin
    ctrl_out = ctrl_q;
    ctrl_out[CHANNEL_RUN_BIT] = run_q;
  end
  assign src_addr_out = src_q;
  assign dst_addr_out = dst_q;
  assign count_out = count_q;
  assign irq_out = irq_q;

endmodule // dma_channel_regs

// ---- rtl/dma_rank_arbiter.sv ----
/*
  dma_rank_arbiter: picks one of two requesting channels by rank bit,
  alternating between them when ranks are equal.
  assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module dma_rank_arbiter
  import dma_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // requests and ranks
  input wire logic [1:0] req_in,
  input wire logic [1:0] high_rank_in,
  input wire logic take_in,
  // one-hot grant
  output logic [1:0] grant_out
);

  logic last_q;
  logic both_req;
  logic rank_tie;
  logic pick_one;

  // decode: rank first, then alternate on a tie
  assign both_req = req_in[0] && req_in[1];
  assign rank_tie = high_rank_in[0] == high_rank_in[1];
  assign pick_one = both_req ? (rank_tie ? !last_q : high_rank_in[1])
                             : req_in[1];
  assign grant_out = (req_in == 2'h0) ? 2'h0 : (pick_one ? 2'h2 : 2'h1);

  // remember who was served last so a tie flips next time
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      last_q <= 1'b1;
    end
    else if (take_in)
    begin
      last_q <= grant_out[1];
    end
  end

endmodule // dma_rank_arbiter

// ---- rtl/dma_two_channel.sv ----
/*
  dma_two_channel: two-channel dma block with an ahb-lite register slave,
  a fetch/store transfer engine and rank-based arbitration.
  assumes request pins are asynchronous, the timer tick and the transfer
  acknowledge come from logic on clk_sys_in, and the bus never waits.
*/
`timescale 1ns/1ps

module dma_two_channel
  import dma_ctrl_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // request sources
  input wire logic [CHANNELS-1:0] drq_in,
  input wire logic timer_tick_in,
  // transfer port towards memory and i/o
  output logic xfer_req_out,
  output logic xfer_write_out,
  output logic xfer_mem_space_out,
  output logic xfer_byte_out,
  output logic [19:0] xfer_addr_out,
  output logic [15:0] xfer_wdata_out,
  input wire logic xfer_ack_in,
  input wire logic [15:0] xfer_rdata_in,
  // completion interrupts, one pulse per channel
  output logic [CHANNELS-1:0] dma_irq_out
);

  // ----------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------
  logic addr_valid;
  logic [7:0] addr_idx;
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;

  // a transfer is taken only on a nonseq/seq slot while the bus is ready
  assign addr_valid = hsel_in && htrans_in[1] && hready_in;
  assign addr_idx = haddr_in[IDX_MSB:IDX_LSB];

  // writes land one cycle later with hwdata; reads are sampled here so
  // hrdata comes from a flop with no wait state
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= addr_valid && hwrite_in;
      if (addr_valid)
      begin
        wr_idx_q <= addr_idx;
      end
      if (addr_valid && !hwrite_in)
      begin
        rdata_q <= rd_word;
      end
    end
  end

  // the slave never stalls and always answers okay; hsize is not checked
  // because only whole-word accesses are supported
  assign hreadyout_out = 1'b1;
  assign hresp_out = HRESP_OKAY;
  assign hrdata_out = rdata_q;

  // ----------------------------------------------------------------
  // request pin synchronisers
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] drq_meta_q;
  logic [CHANNELS-1:0] drq_sync_q;

  // two flops; only the second one is read by channel logic
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      drq_meta_q <= '0;
      drq_sync_q <= '0;
    end
    else
    begin
      drq_meta_q <= drq_in;
      drq_sync_q <= drq_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] ch_req;
  logic [CHANNELS-1:0] ch_done;
  logic [CHANNELS-1:0] ch_wr;
  logic [15:0] ch_ctrl [CHANNELS];
  logic [19:0] ch_src [CHANNELS];
  logic [19:0] ch_dst [CHANNELS];
  logic [15:0] ch_count [CHANNELS];
  logic [1:0] grant;
  logic [1:0] high_rank;
  logic take;

  // write strobes by channel block nibble of the index
  assign ch_wr[0] = wr_pend_q && (wr_idx_q[7:4] == CH0_BLOCK);
  assign ch_wr[1] = wr_pend_q && (wr_idx_q[7:4] == CH1_BLOCK);

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_chan
      dma_channel_regs u_regs (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(ch_wr[gi]),
        .wr_reg_in(wr_idx_q[3:0]),
        .wdata_in(hwdata_in[15:0]),
        .drq_in(drq_sync_q[gi]),
        .timer_tick_in(timer_tick_in),
        .done_in(ch_done[gi]),
        .req_out(ch_req[gi]),
        .ctrl_out(ch_ctrl[gi]),
        .src_addr_out(ch_src[gi]),
        .dst_addr_out(ch_dst[gi]),
        .count_out(ch_count[gi]),
        .irq_out(dma_irq_out[gi])
      );
      assign high_rank[gi] = ch_ctrl[gi][RANK_BIT];
    end
  endgenerate

  // ----------------------------------------------------------------
  // register readback
  // ----------------------------------------------------------------
  logic rd_ch_hit;
  logic rd_ch;
  logic [15:0] rd_half;

  // the block nibble picks the channel, the low nibble the register;
  // unmapped indices read zero
  assign rd_ch = addr_idx[7:4] == CH1_BLOCK;
  assign rd_ch_hit = (addr_idx[7:4] == CH0_BLOCK) || rd_ch;
  assign rd_half =
    (addr_idx[3:0] == REG_SRC_LO) ? ch_src[rd_ch][15:0] :
    (addr_idx[3:0] == REG_SRC_HI) ? {12'h000, ch_src[rd_ch][19:16]} :
    (addr_idx[3:0] == REG_DST_LO) ? ch_dst[rd_ch][15:0] :
    (addr_idx[3:0] == REG_DST_HI) ? {12'h000, ch_dst[rd_ch][19:16]} :
    (addr_idx[3:0] == REG_COUNT) ? ch_count[rd_ch] :
    (addr_idx[3:0] == REG_CTRL) ? ch_ctrl[rd_ch] : 16'h0000;
  assign rd_word = rd_ch_hit ? {16'h0000, rd_half} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  xfer_state_e state_q, state_d;

  // a new grant is taken only from idle, so one transfer finishes first
  assign take = (state_q == XFER_IDLE) && (grant != 2'h0);

  dma_rank_arbiter u_arb (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .req_in(ch_req),
    .high_rank_in(high_rank),
    .take_in(take),
    .grant_out(grant)
  );

  // ----------------------------------------------------------------
  // transfer engine: fetch from source, then store to destination
  // ----------------------------------------------------------------
  logic chan_q, chan_d;
  logic [15:0] data_q;
  logic [19:0] addr_q;
  logic mem_q;
  logic byte_q;
  logic write_q;
  logic [15:0] act_ctrl;

  // the active channel's live control word steers every cycle of the
  // transfer, so a write mid-transfer changes the one in flight
  assign act_ctrl = ch_ctrl[chan_q];

  // state sequencing; the idle cycle between transfers lets a
  // destination-paced device drop its request in time
  always_comb
  begin
    state_d = state_q;
    chan_d = chan_q;
    unique case (state_q)
      XFER_IDLE:
      begin
        if (take)
        begin
          chan_d = grant[1];
          state_d = XFER_FETCH;
        end
      end
      XFER_FETCH:
      begin
        if (xfer_ack_in)
        begin
          state_d = XFER_STORE;
        end
      end
      XFER_STORE:
      begin
        if (xfer_ack_in)
        begin
          state_d = XFER_IDLE;
        end
      end
      // the fourth code of the state flop is never entered; recover to idle
      default: state_d = XFER_IDLE;
    endcase
  end

  // completion pulse steps pointers and count of the served channel
  assign ch_done[0] = (state_q == XFER_STORE) && xfer_ack_in && !chan_q;
  assign ch_done[1] = (state_q == XFER_STORE) && xfer_ack_in && chan_q;

  // engine flops; address, space and width follow the live settings
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= XFER_IDLE;
      chan_q <= 1'b0;
      data_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      chan_q <= chan_d;
      if ((state_q == XFER_FETCH) && xfer_ack_in)
      begin
        data_q <= xfer_rdata_in;
      end
    end
  end

  // cycle descriptor for the bus side, picked from live channel state
  always_comb
  begin
    write_q = state_q == XFER_STORE;
    byte_q = !act_ctrl[WORD_BIT];
    if (state_q == XFER_STORE)
    begin
      addr_q = ch_dst[chan_q];
      mem_q = act_ctrl[DST_SPACE_BIT];
    end
    else
    begin
      addr_q = ch_src[chan_q];
      mem_q = act_ctrl[SRC_SPACE_BIT];
    end
  end

  assign xfer_req_out = (state_q == XFER_FETCH) || (state_q == XFER_STORE);
  assign xfer_write_out = write_q;
  assign xfer_mem_space_out = mem_q;
  assign xfer_byte_out = byte_q;
  assign xfer_addr_out = addr_q;
  assign xfer_wdata_out = data_q;

endmodule // dma_two_channel

// ---- tb/dma_two_channel_asserts.sv ----
/*
  dma_two_channel_asserts: port-level checks of the two-channel dma block.
  assumes one clock, the async active-high reset and hready tied to hreadyout.
*/
`timescale 1ns/1ps
module dma_two_channel_asserts
#(
  parameter int CHANNELS = 2
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // register bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  // transfer port and interrupts
  input wire logic xfer_req_out,
  input wire logic xfer_write_out,
  input wire logic [15:0] xfer_wdata_out,
  input wire logic xfer_ack_in,
  input wire logic [15:0] xfer_rdata_in,
  input wire logic [CHANNELS-1:0] dma_irq_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------------------------------
  // steps of a register read and of a transfer
  // ----------------------------------------------------------------
  sequence s_rd_ctrl;
    hsel_in && htrans_in[1] && !hwrite_in && haddr_in[9:2] == 8'hCA ##1 1'b1;
  endsequence
  sequence s_fetch_done;
    xfer_req_out && !xfer_write_out && xfer_ack_in;
  endsequence
  sequence s_store_done;
    xfer_req_out && xfer_write_out && xfer_ack_in;
  endsequence

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_BUS_READY: assert property (hreadyout_out)
    else $error("register slave stalled");
  AST_BUS_OKAY: assert property (hresp_out == 1'b0)
    else $error("register slave answered an error");
  // gate and reserved bits never come back, nor the unused upper half
  AST_CTRL_READ: assert property (s_rd_ctrl |-> hrdata_out[3:2] == 2'h0
    && hrdata_out[31:16] == 16'h0000) else $error("control readback shows unstored bits");
  AST_REQ_HOLD: assert property (xfer_req_out && !xfer_ack_in
    |=> xfer_req_out && $stable(xfer_write_out)) else $error("bus cycle dropped before ack");
  AST_FETCH_STORE: assert property (s_fetch_done |=> xfer_req_out && xfer_write_out)
    else $error("fetch not followed by store");
  AST_STORE_IDLE: assert property (s_store_done |=> !xfer_req_out)
    else $error("no idle cycle after store");
  AST_WDATA: assert property (s_fetch_done |=> xfer_wdata_out == $past(xfer_rdata_in))
    else $error("stored data differs from fetched data");
  // an interrupt only ever follows a completed store
  AST_IRQ_CAUSE: assert property ((|dma_irq_out)
    |-> $past(xfer_ack_in) && $past(xfer_write_out))
    else $error("interrupt without a finished transfer");
  AST_IRQ_PULSE: assert property ((|dma_irq_out) |=> dma_irq_out == '0)
    else $error("interrupt longer than one cycle");
endmodule // dma_two_channel_asserts

bind dma_two_channel dma_two_channel_asserts #(.CHANNELS(CHANNELS)) chk_u (.clk_sys_in,
  .sys_rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hreadyout_out, .hresp_out,
  .hrdata_out, .xfer_req_out, .xfer_write_out, .xfer_wdata_out, .xfer_ack_in,
  .xfer_rdata_in, .dma_irq_out);

// ---- tb/testbench.sv ----
/*
  testbench: programs the dma block over ahb-lite and compares every
  finished bus cycle with a queue model. assumes the memory model answers.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in, sys_rst_in, hsel, hwrite, hready, tick, req, wr, space, byte_w, ack;
  logic [1:0] htrans, drq, slow, irq;
  logic [31:0] haddr, hwdata, hrdata, junk;
  logic [19:0] addr;
  logic [15:0] rdata, rnd, c;
  logic [31:0] exp_q[$];
  int fail_count, cmp_count, irq_n;

  dma_two_channel dut_u (.clk_sys_in, .sys_rst_in, .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(), .hrdata_out(hrdata),
    .drq_in(drq), .timer_tick_in(tick), .xfer_req_out(req), .xfer_write_out(wr),
    .xfer_mem_space_out(space), .xfer_byte_out(byte_w), .xfer_addr_out(addr),
    .xfer_wdata_out(), .xfer_ack_in(ack), .xfer_rdata_in(rdata), .dma_irq_out(irq));
  xfer_mem_model mem_u (.clk_sys_in, .sys_rst_in, .xfer_req_in(req), .xfer_mem_space_in(space),
    .xfer_addr_in(addr), .wait_in(slow), .xfer_ack_out(ack), .xfer_rdata_out(rdata));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // pointer step from {down, up}; both or neither hold the pointer
  function automatic logic [19:0] step(input logic [1:0] du, input int st);
    return du == 2'h1 ? 20'(st) : du == 2'h2 ? 20'(0 - st) : 20'h00000;
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      fail_count++;
    end
  endtask
  task automatic results;
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one single transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_sys_in);
    while (hready !== 1'b1) @(posedge clk_sys_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_in);
    while (hready !== 1'b1) @(posedge clk_sys_in);
    r = hrdata;
  endtask
  task automatic wreg(input logic [31:0] a, input logic [15:0] d);
    ahb(1'b1, a, {16'h0000, d}, junk);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [15:0] e);
    ahb(1'b0, a, 32'h0, junk);
    chk({16'h0000, e}, junk);
  endtask
  // load random pointers and a count, queue the n predicted pairs, then
  // write the control word last so the channel starts fully set up
  task automatic setup(input int ch, input logic [15:0] cw, input logic [15:0] cnt,
    input int n);
    logic [31:0] b;
    logic [19:0] s, d;
    int st;
    b = 32'h300 + 32'(ch) * 32'h40;
    rnd = lfsr(rnd);
    s = {rnd[3:0], rnd};
    rnd = lfsr(rnd);
    d = {rnd[7:4], rnd};
    st = cw[0] ? 2 : 1;
    wreg(b, s[15:0]);
    wreg(b + 32'h08, {12'h000, s[19:16]});
    wreg(b + 32'h10, d[15:0]);
    wreg(b + 32'h18, {12'h000, d[19:16]});
    wreg(b + 32'h20, cnt);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back({9'h000, 1'b0, cw[12], ~cw[0], s});
      exp_q.push_back({9'h000, 1'b1, cw[15], ~cw[0], d});
      s = s + step(cw[11:10], st);
      d = d + step(cw[14:13], st);
    end
    wreg(b + 32'h28, cw);
  endtask
  task automatic drain;
    repeat (4000)
      if (exp_q.size() != 0)
        @(posedge clk_sys_in);
    repeat (12) @(posedge clk_sys_in);
  endtask

  // ----------------------------------------------------------------
  // clock, monitors, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // an unpredicted cycle meets an empty queue and fails
  always @(posedge clk_sys_in)
  begin
    if (!sys_rst_in && req === 1'b1 && ack === 1'b1)
      chk(exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF,
        {9'h0, wr, space, byte_w, addr});
    if (irq[0] === 1'b1)
      irq_n++;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    results();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst_in = 1'b1;
    {hsel, hwrite, tick, htrans, drq, slow, haddr, hwdata} = '0;
    {fail_count, cmp_count, irq_n} = '0;
    rnd = 16'h5736;
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rdc(32'h328, 16'h0000);
    rdc(32'h368, 16'h0000);
    rdc(32'h000, 16'h0000);
    // mode 11 keeps the channel quiet while the run bit is exercised
    wreg(32'h328, 16'hFFFF);
    rdc(32'h328, 16'hFFF3);
    wreg(32'h328, 16'hFFF9);
    rdc(32'h328, 16'hFFF3);
    wreg(32'h328, 16'h00C4);
    rdc(32'h328, 16'h00C0);
    // unpaced runs over all four direction settings of each pointer, both widths and spaces
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      slow <= rnd[1:0];
      c = {rnd[15], k[1:0], rnd[12], 2'(k + 1), 2'h1, 5'h00, 2'h3, k[2]};
      setup(0, c, 16'(2 + k[0]), 2 + k[0]);
      drain();
      rdc(32'h320, 16'h0000);
      rdc(32'h328, c & 16'hFFF1);
      chk(32'(k + 1), irq_n);
    end
    // source paced, halt at count end, channel 1 ranked above channel 0
    slow <= 2'h1;
    setup(1, 16'hB667, 16'h0002, 2);
    setup(0, 16'hB646, 16'h0002, 2);
    drq <= 2'h3;
    drain();
    rdc(32'h368, 16'hB663);
    rdc(32'h360, 16'h0000);
    drq <= 2'h0;
    // destination paced by timer ticks, counting on past zero
    setup(0, 16'hB497, 16'h0001, 3);
    for (int i = 0; i < 3; i++)
    begin
      tick <= 1'b1;
      @(posedge clk_sys_in);
      tick <= 1'b0;
      repeat (200)
        if (exp_q.size() > 4 - 2 * i)
          @(posedge clk_sys_in);
    end
    drain();
    rdc(32'h320, 16'hFFFE);
    rdc(32'h328, 16'hB493);
    wreg(32'h328, 16'h0004);
    rdc(32'h328, 16'h0000);
    // equal ranks: channel 0 was served last, so the tie goes to channel 1 first
    setup(1, 16'hB647, 16'h0001, 1);
    setup(0, 16'hB646, 16'h0001, 1);
    drq <= 2'h3;
    drain();
    drq <= 2'h0;
    results();
  end
endmodule // testbench

// ---- tb/xfer_mem_model.sv ----
/*
  xfer_mem_model: memory and i/o space answering the dma transfer port.
  assumes requests are held until ack and all signals share one clock.
*/
`timescale 1ns/1ps
module xfer_mem_model
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // transfer port
  input wire logic xfer_req_in,
  input wire logic xfer_mem_space_in,
  input wire logic [19:0] xfer_addr_in,
  input wire logic [1:0] wait_in,
  output logic xfer_ack_out,
  output logic [15:0] xfer_rdata_out
);
  logic [1:0] wait_q;

  // answer after wait_in cycles; an idle read bus flips every cycle so
  // stale data can never pass for a real answer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      xfer_ack_out <= 1'b0;
      wait_q <= 2'h0;
      xfer_rdata_out <= 16'h0000;
    end
    else
    begin
      xfer_ack_out <= 1'b0;
      if (xfer_req_in && !xfer_ack_out && wait_q == wait_in)
      begin
        xfer_ack_out <= 1'b1;
        wait_q <= 2'h0;
        xfer_rdata_out <= {xfer_addr_in[7:0], xfer_addr_in[15:8]} ^ {16{xfer_mem_space_in}};
      end
      else if (!xfer_ack_out)
      begin
        xfer_rdata_out <= ~xfer_rdata_out;
        wait_q <= xfer_req_in ? wait_q + 2'h1 : 2'h0;
      end
    end
  end
endmodule // xfer_mem_model
